// >>> src/secc_pkg.sv
// constants, types and the code-to-voltage map shared by both ends of the sideband link
// assumes a single 125 MHz clock on both ends
package secc_pkg;

   // clock
   localparam int CLK_MHZ          = 125;
   localparam int CLK_PERIOD_NS    = 8;

   // code debounce window 100..400 ns, 200 ns chosen; least time rounds up
   localparam int DEB_NS           = 200;
   localparam int DEB_CYC          = (DEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // least low time of the done pin and least hold time of a code combination
   localparam int DONE_MIN_NS      = 500;
   localparam int DONE_MIN_CYC     = (DONE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_NS          = 500;
   localparam int HOLD_CYC         = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // rail ramp model; must stay below the 30 ms exit budget
   localparam int EXIT_MAX_MS      = 30;
   localparam int RAMP_US          = 1000;
   localparam int RAMP_CYC         = RAMP_US * CLK_MHZ;
   // core slew: one 12.5 mV code at 25 mV/ms gives one code per 500 us
   localparam int STEP_UV          = 12500;
   localparam int SLEW_MV_PER_MS   = 25;
   localparam int SLEW_STEP_US     = STEP_UV / SLEW_MV_PER_MS;
   localparam int SLEW_CYC         = SLEW_STEP_US * CLK_MHZ;
   // thermal shutdown budget, shared evenly between rails (longest time rounds down)
   localparam int TRIP_MS          = 500;
   localparam int N_REG            = 8;
   localparam int TRIP_STEP_CYC    = (TRIP_MS * 1000 * CLK_MHZ) / N_REG;

   // regulator indices
   localparam int RAIL_MAIN_IO     = 0;
   localparam int RAIL_MEMORY_IO   = 1;
   localparam int RAIL_ANALOG_CORE = 2;
   localparam int RAIL_ONE_EIGHT   = 3;
   localparam int RAIL_MEM_SUPPLY  = 4;
   localparam int N_CORE_STANDBY   = 4;
   localparam int N_COLD_BOOT      = 5;

   // per-rail standby-exit setting
   localparam int         EXIT_COPY_BIT   = 5;
   localparam logic [1:0] ACT_NONE        = 2'h0;
   localparam logic [1:0] ACT_ON          = 2'h1;
   localparam logic [1:0] ACT_OFF         = 2'h2;
   localparam logic [5:0] EXIT_CFG_CORE   = 6'h21;
   localparam logic [5:0] EXIT_CFG_OTHER  = 6'h00;

   // target select encodings
   localparam logic [1:0] SEL_INVALID     = 2'h0;
   localparam logic [1:0] SEL_CORE        = 2'h1;
   localparam logic [1:0] SEL_UNCORE      = 2'h2;
   localparam logic [1:0] SEL_UNUSED      = 2'h3;

   // code map, voltages in units of 0.1 mV
   localparam logic [6:0]  CODE_FLAT_MAX  = 7'h18;
   localparam logic [6:0]  CODE_LOW_MAX   = 7'h60;
   localparam logic [13:0] MV_X10_TOP     = 14'h2ee0;
   localparam logic [13:0] MV_X10_STEP    = 14'h007d;
   localparam logic [13:0] MV_X10_OFF     = 14'h0000;

   // device registers
   localparam logic [8:0] REG_CORE_IMG    = 9'h1c9;
   localparam logic [8:0] REG_UNCORE_IMG  = 9'h1ca;
   localparam logic [6:0] IMG_RST         = 7'h7f;

   // host controller registers (APB byte addresses) and fields
   localparam logic [7:0] HREG_CTRL       = 8'h00;
   localparam logic [7:0] HREG_CODE       = 8'h04;
   localparam logic [7:0] HREG_STAT       = 8'h08;
   localparam int CTRL_EXIT_BIT           = 0;
   localparam int CTRL_TRIP_BIT           = 1;
   localparam int CODE_SEL_LSB            = 8;
   localparam int STAT_DONE_BIT           = 0;
   localparam int STAT_BUSY_BIT           = 1;
   localparam int STAT_REFUSED_BIT        = 2;

   typedef enum logic [1:0] {
      SECC_RUN  = 2'b00,
      SECC_RAMP = 2'b01,
      SECC_TRIP = 2'b10,
      SECC_SHUT = 2'b11
   } secc_dev_state_t;

   function automatic logic [13:0] code_to_mv_x10(input logic [6:0] code);
      logic [13:0] drop;
      drop = 14'(code - CODE_FLAT_MAX) * MV_X10_STEP;
      if (code <= CODE_FLAT_MAX) begin
         return MV_X10_TOP;
      end else if (code <= CODE_LOW_MAX) begin
         return MV_X10_TOP - drop;
      end
      return MV_X10_OFF;
   endfunction

endpackage

// >>> src/secc_sideband_if.sv
// sideband pins between the power device and the cpu / hub controller
// assumes both ends share one clock; all pins are plain one-way levels
`timescale 1ns/1ps
interface secc_sideband_if;
   logic       standby_exit_in;
   logic       thermal_trip_n;
   logic [1:0] target_select;
   logic [6:0] voltage_code;
   logic       rail_change_done;

   modport dev (
      input  standby_exit_in,
      input  thermal_trip_n,
      input  target_select,
      input  voltage_code,
      output rail_change_done
   );

   modport host (
      output standby_exit_in,
      output thermal_trip_n,
      output target_select,
      output voltage_code,
      input  rail_change_done
   );
endinterface

// >>> src/secc_host.sv
// cpu / hub end: drives the sideband pins from APB registers
// assumes APB on mclk_i; software sequences codes, this end only enforces hold time
`timescale 1ns/1ps
module secc_host (
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        reset_n_i,
   // apb slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // sideband pins
   secc_sideband_if.host    sb
);

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic        exit_drv;
      logic        trip_drv;
      logic [6:0]  code;
      logic [1:0]  sel;
      logic [7:0]  hold_cnt;
      logic        refused;
      logic [2:0]  done_sync;
      logic        done_f;
   } host_state_t;

   host_state_t q;
   host_state_t n;

   logic setup;
   logic wr;
   logic busy;

   always_comb begin
      n     = q;
      setup = psel_i & ~penable_i;
      wr    = psel_i & penable_i & pwrite_i & q.pready;
      busy  = (q.hold_cnt != 8'h00);
      n.pready = 1'b1;

      n.done_sync = {q.done_sync[1:0], sb.rail_change_done};
      if (q.done_sync[1] == q.done_sync[2]) begin
         n.done_f = q.done_sync[2];
      end

      if (busy) begin
         n.hold_cnt = q.hold_cnt - 8'h01;
      end

      // read data is sampled in setup so that it comes from a flop in the access phase
      if (setup) begin
         n.prdata  = '0;
         n.pslverr = 1'b0;
         unique case (paddr_i)
            secc_pkg::HREG_CTRL: begin
               n.prdata[secc_pkg::CTRL_EXIT_BIT] = q.exit_drv;
               n.prdata[secc_pkg::CTRL_TRIP_BIT] = q.trip_drv;
            end
            secc_pkg::HREG_CODE: begin
               n.prdata[6:0] = q.code;
               n.prdata[secc_pkg::CODE_SEL_LSB +: 2] = q.sel;
            end
            secc_pkg::HREG_STAT: begin
               n.prdata[secc_pkg::STAT_DONE_BIT]    = q.done_f;
               n.prdata[secc_pkg::STAT_BUSY_BIT]    = busy;
               n.prdata[secc_pkg::STAT_REFUSED_BIT] = q.refused;
            end
            default: n.pslverr = 1'b1;
         endcase
      end

      if (wr) begin
         unique case (paddr_i)
            secc_pkg::HREG_CTRL: begin
               n.exit_drv = pwdata_i[secc_pkg::CTRL_EXIT_BIT];
               n.trip_drv = pwdata_i[secc_pkg::CTRL_TRIP_BIT];
            end
            secc_pkg::HREG_CODE: begin
               if (busy) begin
                  n.refused = 1'b1;
               end else begin
                  // code and select change in the same edge and then hold
                  n.code     = pwdata_i[6:0];
                  n.sel      = pwdata_i[secc_pkg::CODE_SEL_LSB +: 2];
                  n.hold_cnt = 8'(secc_pkg::HOLD_CYC);
               end
            end
            secc_pkg::HREG_STAT: begin
               // a refusal never falls in the same cycle as the clear; each needs its own APB write
               if (pwdata_i[secc_pkg::STAT_REFUSED_BIT]) begin
                  n.refused = 1'b0;
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         q           <= '0;
         q.done_sync <= 3'h7;
         q.done_f    <= 1'b1;
      end else begin
         q <= n;
      end
   end

   assign prdata_o           = q.prdata;
   assign pready_o           = q.pready;
   assign pslverr_o          = q.pslverr;
   assign sb.standby_exit_in = q.exit_drv;
   assign sb.thermal_trip_n  = ~q.trip_drv;
   assign sb.voltage_code    = q.code;
   assign sb.target_select   = q.sel;

endmodule

// >>> src/secc_device.sv
// power device end: standby exit, thermal shutdown and voltage code decode
// assumes sideband pins are asynchronous; user side is on mclk_i
//
// Implementation choice: a plain register read port, address in and registered byte out.
`timescale 1ns/1ps
module secc_device #(
   parameter int N_REG         = secc_pkg::N_REG,
   parameter int RAMP_CYC      = secc_pkg::RAMP_CYC,
   parameter int SLEW_CYC      = secc_pkg::SLEW_CYC,
   parameter int TRIP_STEP_CYC = secc_pkg::TRIP_STEP_CYC,
   localparam int IDX_W        = $clog2(N_REG)
) (
   // clock and reset
   input  wire logic             mclk_i,
   input  wire logic             reset_n_i,
   // sideband pins
   secc_sideband_if.dev          sb,
   // standby-exit setting writes
   input  wire logic             cfg_we_i,
   input  wire logic [IDX_W-1:0] cfg_idx_i,
   input  wire logic [5:0]       cfg_data_i,
   // register-sourced codes and source select, bit 0 core, bit 1 uncore
   input  wire logic [1:0]       src_sel_i,
   input  wire logic [6:0]       sw_core_code_i,
   input  wire logic [6:0]       sw_uncore_code_i,
   // power-on event after thermal shutdown
   input  wire logic             power_on_event_i,
   // register read port
   input  wire logic [8:0]       reg_addr_i,
   output logic      [7:0]       reg_rdata_o,
   // rail state
   output logic      [N_REG-1:0] rail_en_o,
   output logic      [6:0]       core_code_o,
   output logic      [13:0]      core_mv_x10_o,
   output logic      [13:0]      uncore_mv_x10_o
);

   typedef struct packed {
      logic [10:0]                 s1;
      logic [10:0]                 s2;
      logic [10:0]                 s3;
      logic [10:0]                 filt;
      logic                        exit_prev;
      logic                        trip_prev;
      secc_pkg::secc_dev_state_t   st;
      logic [31:0]                 timer;
      logic [7:0]                  low_cnt;
      logic                        done;
      logic [N_REG-1:0]            en;
      logic [N_REG-1:0][5:0]       exit_cfg;
      logic [8:0]                  deb_val;
      logic [7:0]                  deb_cnt;
      logic                        deb_done;
      logic [6:0]                  core_img;
      logic [6:0]                  uncore_img;
      logic [6:0]                  core_cur;
      logic [31:0]                 slew_cnt;
      logic [IDX_W-1:0]            trip_idx;
      logic [7:0]                  rdata;
      logic [13:0]                 core_mv;
      logic [13:0]                 uncore_mv;
   } dev_state_t;

   // sync vector: exit, trip_n, select, code
   localparam logic [10:0] SYNC_RST = 11'h200;

   dev_state_t q;
   dev_state_t n;

   function automatic logic [N_REG-1:0] exit_apply(input logic [N_REG-1:0] old_en,
                                                   input logic [N_REG-1:0][5:0] cfg);
      logic [N_REG-1:0] e;
      e = old_en;
      for (int i = 0; i < N_REG; i++) begin
         if (cfg[i][secc_pkg::EXIT_COPY_BIT]) begin
            if (cfg[i][1:0] == secc_pkg::ACT_ON) begin
               e[i] = 1'b1;
            end else if (cfg[i][1:0] == secc_pkg::ACT_OFF) begin
               e[i] = 1'b0;
            end
         end
      end
      if (!old_en[secc_pkg::RAIL_ANALOG_CORE] && !e[secc_pkg::RAIL_MEM_SUPPLY]) begin
         e[secc_pkg::RAIL_ANALOG_CORE] = 1'b0;
      end
      return e;
   endfunction

   function automatic logic [N_REG-1:0] cold_boot_en();
      logic [N_REG-1:0] e;
      e = '0;
      for (int i = 0; i < secc_pkg::N_COLD_BOOT; i++) begin
         e[i] = 1'b1;
      end
      return e;
   endfunction

   logic             exit_f;
   logic             trip_f;
   logic             exit_rise;
   logic             trip_go;
   logic [N_REG-1:0] new_en;
   logic [6:0]       core_tgt;
   logic [6:0]       uncore_set;

   always_comb begin
      n = q;
      n.s1 = {sb.standby_exit_in, sb.thermal_trip_n, sb.target_select, sb.voltage_code};
      n.s2 = q.s1;
      n.s3 = q.s2;
      n.filt = (q.s3 & ~(q.s2 ^ q.s3)) | (q.filt & (q.s2 ^ q.s3));
      exit_f = q.filt[10];
      trip_f = q.filt[9];
      n.exit_prev = exit_f;
      n.trip_prev = trip_f;
      exit_rise = exit_f & ~q.exit_prev;
      trip_go = q.trip_prev & ~trip_f & q.en[secc_pkg::RAIL_MAIN_IO]
                & ((q.st == secc_pkg::SECC_RUN) | (q.st == secc_pkg::SECC_RAMP));
      new_en = exit_apply(q.en, q.exit_cfg);

      if (cfg_we_i && (32'(cfg_idx_i) < N_REG)) begin
         n.exit_cfg[cfg_idx_i] = cfg_data_i;
      end

      n.timer = q.timer + 32'h1;
      unique case (q.st)
         secc_pkg::SECC_RUN: begin
            if (trip_go) begin
               n.st       = secc_pkg::SECC_TRIP;
               n.timer    = '0;
               n.trip_idx = IDX_W'(N_REG - 1);
            end else if (exit_rise) begin
               n.en    = new_en;
               n.timer = '0;
               // only rails that switch on need a ramp
               n.st    = |(new_en & ~q.en) ? secc_pkg::SECC_RAMP : secc_pkg::SECC_RUN;
            end
         end
         secc_pkg::SECC_RAMP: begin
            if (trip_go) begin
               n.st       = secc_pkg::SECC_TRIP;
               n.timer    = '0;
               n.trip_idx = IDX_W'(N_REG - 1);
            end else if (q.timer >= 32'(RAMP_CYC - 1)) begin
               n.st = secc_pkg::SECC_RUN;
            end
         end
         secc_pkg::SECC_TRIP: begin
            if (q.timer >= 32'(TRIP_STEP_CYC - 1)) begin
               n.en[q.trip_idx] = 1'b0;
               n.timer = '0;
               if (q.trip_idx == '0) begin
                  n.st = secc_pkg::SECC_SHUT;
               end else begin
                  n.trip_idx = q.trip_idx - IDX_W'(1);
               end
            end
         end
         secc_pkg::SECC_SHUT: begin
            if (power_on_event_i) begin
               n.en    = cold_boot_en();
               n.timer = '0;
               n.st    = secc_pkg::SECC_RAMP;
            end
         end
      endcase

      // done pin: low through exit and ramp, and never shorter than the least low time
      if (exit_rise) begin
         n.low_cnt = '0;
      end else if (q.low_cnt < 8'(secc_pkg::DONE_MIN_CYC)) begin
         n.low_cnt = q.low_cnt + 8'h01;
      end
      n.done = ~exit_f & (q.st != secc_pkg::SECC_RAMP) & (q.low_cnt == 8'(secc_pkg::DONE_MIN_CYC));

      // code and select are debounced as one word
      if (q.filt[8:0] != q.deb_val) begin
         n.deb_val  = q.filt[8:0];
         n.deb_cnt  = '0;
         n.deb_done = 1'b0;
      end else if (q.deb_cnt < 8'(secc_pkg::DEB_CYC)) begin
         n.deb_cnt = q.deb_cnt + 8'h01;
      end else if (!q.deb_done) begin
         n.deb_done = 1'b1;
         if (q.en[secc_pkg::RAIL_MAIN_IO]) begin
            unique case (q.deb_val[8:7])
               secc_pkg::SEL_CORE:   n.core_img   = q.deb_val[6:0];
               secc_pkg::SEL_UNCORE: n.uncore_img = q.deb_val[6:0];
               default: ;
            endcase
         end
      end

      core_tgt   = src_sel_i[0] ? sw_core_code_i : q.core_img;
      uncore_set = src_sel_i[1] ? sw_uncore_code_i : q.uncore_img;
      // one code per step period bounds the slew; a new target waits a full period only if the core sat at its old target
      if (q.core_cur == core_tgt) begin
         n.slew_cnt = '0;
      end else if (q.slew_cnt >= 32'(SLEW_CYC - 1)) begin
         n.slew_cnt = '0;
         n.core_cur = (core_tgt > q.core_cur) ? q.core_cur + 7'h01 : q.core_cur - 7'h01;
      end else begin
         n.slew_cnt = q.slew_cnt + 32'h1;
      end
      n.core_mv   = secc_pkg::code_to_mv_x10(q.core_cur);
      n.uncore_mv = secc_pkg::code_to_mv_x10(uncore_set);

      unique case (reg_addr_i)
         secc_pkg::REG_CORE_IMG:   n.rdata = {1'b0, q.core_img};
         secc_pkg::REG_UNCORE_IMG: n.rdata = {1'b0, q.uncore_img};
         default:                  n.rdata = 8'h00;
      endcase
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         q            <= '0;
         q.s1         <= SYNC_RST;
         q.s2         <= SYNC_RST;
         q.s3         <= SYNC_RST;
         q.filt       <= SYNC_RST;
         q.trip_prev  <= 1'b1;
         q.st         <= secc_pkg::SECC_RUN;
         q.done       <= 1'b1;
         q.low_cnt    <= 8'(secc_pkg::DONE_MIN_CYC);
         q.en         <= cold_boot_en();
         q.deb_val    <= SYNC_RST[8:0];
         q.deb_done   <= 1'b1;
         q.core_img   <= secc_pkg::IMG_RST;
         q.uncore_img <= secc_pkg::IMG_RST;
         q.core_cur   <= secc_pkg::IMG_RST;
         for (int i = 0; i < N_REG; i++) begin
            q.exit_cfg[i] <= (i < secc_pkg::N_CORE_STANDBY) ? secc_pkg::EXIT_CFG_CORE
                                                             : secc_pkg::EXIT_CFG_OTHER;
         end
      end else begin
         q <= n;
      end
   end

   assign sb.rail_change_done = q.done;
   assign reg_rdata_o         = q.rdata;
   assign rail_en_o           = q.en;
   assign core_code_o         = q.core_cur;
   assign core_mv_x10_o       = q.core_mv;
   assign uncore_mv_x10_o     = q.uncore_mv;

endmodule

// >>> tb/secc_properties.sv
// sideband properties: exit pin, done pin and code hold on the link
// assumes one clock; the bench instantiates it beside the interface
`timescale 1ns/1ps
module secc_properties #(
   parameter int RAMP_CYC = 100
) (
   // clock and reset
   input  wire logic       mclk_i,
   input  wire logic       reset_n_i,
   // sideband pins
   input  wire logic       standby_exit_in,
   input  wire logic       thermal_trip_n,
   input  wire logic [1:0] target_select,
   input  wire logic [6:0] voltage_code,
   input  wire logic       rail_change_done
);
   logic [8:0]  prev_q;
   logic [7:0]  hold_q;
   logic [11:0] low_q;
   logic [19:0] rel_q;
   logic        trip_seen_q;
   // hold and low-time counters saturate so long idle stretches never wrap into a false fail
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         prev_q <= 9'h000;
         hold_q <= 8'hff;
         low_q  <= 12'h000;
         rel_q  <= 20'h00000;
         trip_seen_q <= 1'b0;
      end else begin
         // the cold boot after a thermal shutdown ramps too and lowers done with the exit pin low
         trip_seen_q <= standby_exit_in ? 1'b0 : (trip_seen_q | ~thermal_trip_n);
         prev_q <= {target_select, voltage_code};
         hold_q <= ({target_select, voltage_code} != prev_q) ? 8'h00 : ((hold_q == 8'hff) ? hold_q : hold_q + 8'h01);
         low_q  <= rail_change_done ? 12'h000 : ((low_q == 12'hfff) ? low_q : low_q + 12'h001);
         rel_q  <= (rail_change_done || standby_exit_in) ? 20'h00000 : rel_q + 20'h00001;
      end
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   property p_exit_drops; $rose(standby_exit_in) |-> ##[1:8] !rail_change_done; endproperty
   property p_exit_holds; standby_exit_in [*8] |-> !rail_change_done; endproperty
   property p_fall_cause; $fell(rail_change_done) |-> $past(standby_exit_in, 2) || trip_seen_q; endproperty
   property p_rise_quiet; $rose(rail_change_done) |-> !$past(standby_exit_in) && !$past(standby_exit_in, 2); endproperty
   property p_done_steady;
      !standby_exit_in [*6] ##1 (rail_change_done && !standby_exit_in && !trip_seen_q) |=> rail_change_done;
   endproperty
   property p_low_min; $rose(rail_change_done) |-> low_q >= 12'd50; endproperty
   property p_low_max; rel_q <= RAMP_CYC + 100; endproperty
   property p_code_hold; ({target_select, voltage_code} != prev_q) |-> hold_q >= 8'd61; endproperty
   a_exit_drops: assert property (p_exit_drops) else $error("done not lowered after exit rise");
   a_exit_holds: assert property (p_exit_holds) else $error("done high while exit held");
   a_fall_cause: assert property (p_fall_cause) else $error("done fell without exit");
   a_rise_quiet: assert property (p_rise_quiet) else $error("done rose while exit high");
   a_done_steady: assert property (p_done_steady) else $error("done dropped while exit low");
   a_low_min: assert property (p_low_min) else $error("done low time too short");
   a_low_max: assert property (p_low_max) else $error("done low too long after exit");
   a_code_hold: assert property (p_code_hold) else $error("code combination held too briefly");
   c_exit: cover property ($rose(standby_exit_in));
   c_done: cover property ($rose(rail_change_done));
   c_trip: cover property ($fell(thermal_trip_n));
   c_core: cover property (target_select == 2'h1 && $changed(voltage_code));
endmodule

// >>> tb/tb.sv
// bench: apb on the host end, user ports on the device end, link between them
// assumes shortened ramp, slew and trip counts; a few thousand cycles
`timescale 1ns/1ps
module tb;
   localparam int RAMP = 100;
   logic        mclk_i, reset_n_i, psel, penable, pwrite, pready, pslverr, e, cfg_we, pwr_ev;
   logic [7:0]  paddr, reg_rdata, rail_en;
   logic [31:0] pwdata, prdata, r;
   logic [2:0]  cfg_idx;
   logic [5:0]  cfg_data;
   logic [1:0]  src_sel;
   logic [6:0]  sw_core, sw_uncore, core_code;
   logic [8:0]  reg_addr;
   logic [13:0] core_mv, uncore_mv;
   logic [6:0]  ucode [5] = '{7'h10, 7'h18, 7'h19, 7'h60, 7'h61};
   logic [13:0] umv [5]   = '{14'h2ee0, 14'h2ee0, 14'h2e63, 14'h0bb8, 14'h0000};
   int          err_count = 0, n_compared = 0, cyc_n = 0, i;
   secc_sideband_if sb();
   secc_host i_secc_host (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .sb(sb));
   secc_device #(.RAMP_CYC(RAMP), .SLEW_CYC(20), .TRIP_STEP_CYC(50)) i_secc_device (.mclk_i(mclk_i),
      .reset_n_i(reset_n_i), .sb(sb), .cfg_we_i(cfg_we), .cfg_idx_i(cfg_idx), .cfg_data_i(cfg_data),
      .src_sel_i(src_sel), .sw_core_code_i(sw_core), .sw_uncore_code_i(sw_uncore), .power_on_event_i(pwr_ev),
      .reg_addr_i(reg_addr), .reg_rdata_o(reg_rdata), .rail_en_o(rail_en), .core_code_o(core_code),
      .core_mv_x10_o(core_mv), .uncore_mv_x10_o(uncore_mv));
   secc_properties #(.RAMP_CYC(RAMP)) i_secc_properties (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
      .standby_exit_in(sb.standby_exit_in), .thermal_trip_n(sb.thermal_trip_n),
      .target_select(sb.target_select), .voltage_code(sb.voltage_code), .rail_change_done(sb.rail_change_done));
   initial begin
      mclk_i = 1'b0;
      forever #4 mclk_i = ~mclk_i;
   end
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk_i);
      penable <= 1'b1;
      do @(posedge mclk_i); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // the host refuses a second code inside the hold time, so each code waits it out
   task automatic vcode(input logic [1:0] s, input logic [6:0] c);
      apb(1'b1, secc_pkg::HREG_CODE, {22'h0, s, 1'b0, c});
      cyc(70);
   endtask
   task automatic dev_rd(input logic [8:0] a);
      reg_addr <= a;
      cyc(2);
      r = {24'h0, reg_rdata};
   endtask
   task automatic cfg(input logic [2:0] idx, input logic [5:0] d);
      cfg_idx <= idx;
      cfg_data <= d;
      cfg_we <= 1'b1;
      cyc(1);
      cfg_we <= 1'b0;
      cyc(1);
   endtask
   task automatic tally_and_finish;
      $display("compared=%0d errors=%0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   always @(posedge mclk_i) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 20000) begin
         err_count++;
         tally_and_finish();
      end
   end
   initial begin
      {reset_n_i, psel, penable, pwrite, paddr, pwdata, cfg_we, cfg_idx, cfg_data} = '0;
      {src_sel, sw_core, sw_uncore, pwr_ev, reg_addr} = '0;
      cyc(2);
      reset_n_i <= 1'b1;
      dev_rd(secc_pkg::REG_CORE_IMG);
      cmp(r, 32'h7f);
      dev_rd(secc_pkg::REG_UNCORE_IMG);
      cmp(r, 32'h7f);
      cmp(rail_en, 8'h1f);
      apb(1'b0, 8'h10, 32'h0);
      cmp(e, 1'b1);
      for (i = 0; i < 5; i++) begin
         vcode(secc_pkg::SEL_INVALID, 7'h00);
         vcode(secc_pkg::SEL_UNCORE, ucode[i]);
         cmp(uncore_mv, umv[i]);
         dev_rd(secc_pkg::REG_UNCORE_IMG);
         cmp(r, ucode[i]);
      end
      vcode(secc_pkg::SEL_INVALID, 7'h00);
      vcode(secc_pkg::SEL_CORE, 7'h30);
      cmp(core_code >= 7'h7b, 1'b1);
      dev_rd(secc_pkg::REG_CORE_IMG);
      cmp(r, 32'h30);
      cyc(1700);
      cmp(core_code, 7'h30);
      cmp(core_mv, 14'h2328);
      vcode(secc_pkg::SEL_CORE, 7'h31);
      cyc(30);
      cmp(core_code, 7'h31);
      vcode(secc_pkg::SEL_UNUSED, 7'h40);
      dev_rd(secc_pkg::REG_CORE_IMG);
      cmp(r, 32'h31);
      src_sel <= 2'b11;
      sw_uncore <= 7'h20;
      sw_core <= 7'h20;
      cyc(5);
      cmp(uncore_mv, 14'h2af8);
      vcode(secc_pkg::SEL_INVALID, 7'h00);
      vcode(secc_pkg::SEL_UNCORE, 7'h18);
      cmp(uncore_mv, 14'h2af8);
      cyc(250);
      cmp(core_code, 7'h20);
      src_sel <= 2'b00;
      cyc(5);
      cmp(uncore_mv, 14'h2ee0);
      apb(1'b1, secc_pkg::HREG_CODE, 32'h0);
      apb(1'b1, secc_pkg::HREG_CODE, 32'h132);
      apb(1'b0, secc_pkg::HREG_STAT, 32'h0);
      cmp(r[2], 1'b1);
      cmp(r[1:0], 2'h3);
      apb(1'b1, secc_pkg::HREG_STAT, 32'h4);
      apb(1'b0, secc_pkg::HREG_STAT, 32'h0);
      cmp(r[2], 1'b0);
      cyc(70);
      cfg(3'h5, 6'h21);
      cfg(3'h6, 6'h01);
      cfg(3'h3, 6'h22);
      apb(1'b1, secc_pkg::HREG_CTRL, 32'h1);
      cyc(20);
      cmp(sb.rail_change_done, 1'b0);
      apb(1'b1, secc_pkg::HREG_CTRL, 32'h0);
      for (i = 0; i < 400 && sb.rail_change_done !== 1'b1; i++) cyc(1);
      cmp(sb.rail_change_done, 1'b1);
      cmp(rail_en, 8'h37);
      apb(1'b1, secc_pkg::HREG_CTRL, 32'h2);
      apb(1'b0, secc_pkg::HREG_CTRL, 32'h0);
      cmp(r[1:0], 2'h2);
      cyc(120);
      cmp({rail_en[7], rail_en[0]}, 2'b01);
      cyc(450);
      cmp(rail_en, 8'h00);
      apb(1'b1, secc_pkg::HREG_CTRL, 32'h0);
      vcode(secc_pkg::SEL_UNCORE, 7'h30);
      dev_rd(secc_pkg::REG_UNCORE_IMG);
      cmp(r, 32'h18);
      pwr_ev <= 1'b1;
      cyc(1);
      pwr_ev <= 1'b0;
      cyc(RAMP + 50);
      cmp(rail_en, 8'h1f);
      tally_and_finish();
   end
endmodule
